// ### rtcal_regs.sv
// Hour, calendar and alarm-match registers of the battery-well clock.
// Assumes one clock domain; time strobes and format bits come from the
// rest of the clock on mclk, so none of them is synchronised here.
//
// Behaviour
// - Minutes alarm compared with current minutes
// - Alarm top bits 11 mean always matching
// - Hours alarm compared with hour register
// - 12-hour mode: top hour bit PM flag
// - Hour in low seven bits, 1-12 or 0-23
// - Weekday counts 1 Sunday through 7 Saturday
// - Weekday identical in binary and BCD
// - Monthday_count holds 1 through 31
// - Month holds 1 through 12
// - Hour, day, month shown binary or BCD
// - Seconds alarm compared with seconds count too
// - Alarm interrupt only while enable set
`timescale 1ns/1ps
module rtcal_regs (
    input wire logic mclk,
    input wire logic rst,
    // Register port
    input wire logic [5:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Format and enable bits held elsewhere in the clock
    input wire logic binary_format_select,
    input wire logic hour_24_select,
    input wire logic alarm_int_enable,
    input wire logic leap_year,
    // Time state held elsewhere
    input wire logic [7:0] seconds_now,
    input wire logic [7:0] minutes_now,
    input wire logic hour_tick,
    input wire logic time_updated,
    // Events
    output logic alarm_event,
    output logic alarm_irq,
    output logic day_advance
);
    logic [7:0] sec_alarm_r;
    logic [7:0] minutes_alarm_match_r;
    logic [7:0] hour_count_r;
    logic [7:0] hour_alarm_match_r;
    logic [7:0] weekday_count_r;
    logic [7:0] monthday_count_r;
    logic [7:0] calendar_month_count_r;
    logic [7:0] reg_rdata_r;
    logic alarm_event_r;
    logic alarm_irq_r;
    logic day_advance_r;

    logic bcd;
    logic wr_sec_alarm;
    logic wr_min_alarm;
    logic wr_hour;
    logic wr_hour_alarm;
    logic wr_weekday;
    logic wr_monthday;
    logic wr_month;

    logic [7:0] hour_first;
    logic [7:0] hour_last;
    logic [7:0] hour_nxt;
    logic [7:0] hour_bin;
    logic hour_wrap;
    logic half_day_flag;
    logic half_day_nxt;
    logic day_carry;

    logic [7:0] weekday_value_nxt;
    logic [7:0] monthday_value_nxt;
    logic [7:0] month_nxt;
    logic [7:0] month_bin;
    logic monthday_wrap;
    logic [7:0] days_in_month;

    logic sec_match;
    logic min_match;
    logic hour_match;
    logic all_match;
    localparam int ALARM_FIELDS = 3;
    logic [7:0] alarm_val [ALARM_FIELDS];
    logic [7:0] time_val [ALARM_FIELDS];
    logic [ALARM_FIELDS-1:0] field_match;

    // The binary_format_select input is high for binary presentation
    assign bcd = ~binary_format_select;

    assign wr_sec_alarm = reg_wr && (reg_addr == rtcal_pkg::OFS_SEC_ALARM);
    assign wr_min_alarm = reg_wr && (reg_addr == rtcal_pkg::OFS_MIN_ALARM);
    assign wr_hour = reg_wr && (reg_addr == rtcal_pkg::OFS_HOUR);
    assign wr_hour_alarm = reg_wr && (reg_addr == rtcal_pkg::OFS_HOUR_ALARM);
    assign wr_weekday = reg_wr && (reg_addr == rtcal_pkg::OFS_WEEKDAY);
    assign wr_monthday = reg_wr && (reg_addr == rtcal_pkg::OFS_MONTHDAY);
    assign wr_month = reg_wr && (reg_addr == rtcal_pkg::OFS_MONTH);

    // Hour stepping: range follows the 12/24 selection
    assign hour_first = hour_24_select ? rtcal_pkg::HOUR24_FIRST
                                       : rtcal_pkg::HOUR12_FIRST;
    assign hour_last = hour_24_select ? rtcal_pkg::HOUR24_LAST
                                      : rtcal_pkg::HOUR12_LAST;
    assign half_day_flag = hour_count_r[rtcal_pkg::HALF_DAY_BIT];

    rtcal_step u_hour_step (
        .cur({1'b0, hour_count_r[rtcal_pkg::HOUR_MSB:0]}),
        .bcd(bcd),
        .first(hour_first),
        .last(hour_last),
        .nxt(hour_nxt),
        .wrap(hour_wrap),
        .bin(hour_bin)
    );

    // Going from 11 to 12 flips the half day; 11 PM to 12 AM ends the day.
    // A write to the hour in the tick cycle drops the tick and its day carry too,
    // so the calendar never moves on a step that the hour register never took
    always_comb begin
        if (hour_24_select) begin
            half_day_nxt = 1'b0;
            day_carry = hour_tick && !wr_hour && hour_wrap;
        end else begin
            half_day_nxt = half_day_flag ^ (hour_bin == rtcal_pkg::HOUR12_TURN);
            day_carry = hour_tick && !wr_hour && half_day_flag &&
                        (hour_bin == rtcal_pkg::HOUR12_TURN);
        end
    end

    // Weekday is stepped as plain binary whatever the presentation
    rtcal_step u_weekday_step (
        .cur(weekday_count_r),
        .bcd(1'b0),
        .first(rtcal_pkg::WEEKDAY_FIRST),
        .last(rtcal_pkg::WEEKDAY_LAST),
        .nxt(weekday_value_nxt),
        .wrap(),
        .bin()
    );

    rtcal_step u_month_step (
        .cur(calendar_month_count_r),
        .bcd(bcd),
        .first(rtcal_pkg::MONTH_FIRST),
        .last(rtcal_pkg::MONTH_LAST),
        .nxt(month_nxt),
        .wrap(),
        .bin(month_bin)
    );

    // Month length; leap years are decided by the year logic outside
    always_comb begin
        if (month_bin == rtcal_pkg::FEBRUARY) begin
            days_in_month = leap_year ? rtcal_pkg::DAYS_FEB_LEAP : rtcal_pkg::DAYS_FEB;
        end else if ((month_bin == rtcal_pkg::APRIL) || (month_bin == rtcal_pkg::JUNE) ||
                     (month_bin == rtcal_pkg::SEPTEMBER) ||
                     (month_bin == rtcal_pkg::NOVEMBER)) begin
            days_in_month = rtcal_pkg::DAYS_SHORT;
        end else begin
            days_in_month = rtcal_pkg::DAYS_LONG;
        end
    end

    rtcal_step u_monthday_step (
        .cur(monthday_count_r),
        .bcd(bcd),
        .first(rtcal_pkg::MONTHDAY_FIRST),
        .last(days_in_month),
        .nxt(monthday_value_nxt),
        .wrap(monthday_wrap),
        .bin()
    );

    // Seconds, minutes and hours alarms are matched alike; the compare is on raw
    // codes, so each alarm must share the encoding of the time it watches
    assign alarm_val[0] = sec_alarm_r;
    assign alarm_val[1] = minutes_alarm_match_r;
    assign alarm_val[2] = hour_alarm_match_r;
    assign time_val[0] = seconds_now;
    assign time_val[1] = minutes_now;
    assign time_val[2] = hour_count_r;

    for (genvar f = 0; f < ALARM_FIELDS; f++) begin : g_field_match
        assign field_match[f] = (alarm_val[f][7:6] == rtcal_pkg::ALARM_ANY) ||
                                (alarm_val[f] == time_val[f]);
    end

    assign sec_match = field_match[0];
    assign min_match = field_match[1];
    assign hour_match = field_match[2];
    assign all_match = sec_match && min_match && hour_match;

    // Software-written alarm values; writes land as given
    always_ff @(posedge mclk) begin
        if (rst) begin
            sec_alarm_r <= rtcal_pkg::REG_RESET;
        end else if (wr_sec_alarm) begin
            sec_alarm_r <= reg_wdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            minutes_alarm_match_r <= rtcal_pkg::REG_RESET;
        end else if (wr_min_alarm) begin
            minutes_alarm_match_r <= reg_wdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            hour_alarm_match_r <= rtcal_pkg::REG_RESET;
        end else if (wr_hour_alarm) begin
            hour_alarm_match_r <= reg_wdata;
        end
    end

    // A software write in the same cycle as a tick wins; the tick is dropped
    always_ff @(posedge mclk) begin
        if (rst) begin
            hour_count_r <= rtcal_pkg::REG_RESET;
        end else if (wr_hour) begin
            hour_count_r <= reg_wdata;
        end else if (hour_tick) begin
            hour_count_r <= {half_day_nxt, hour_nxt[rtcal_pkg::HOUR_MSB:0]};
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            weekday_count_r <= rtcal_pkg::REG_RESET;
        end else if (wr_weekday) begin
            weekday_count_r <= reg_wdata;
        end else if (day_carry) begin
            weekday_count_r <= weekday_value_nxt;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            monthday_count_r <= rtcal_pkg::REG_RESET;
        end else if (wr_monthday) begin
            monthday_count_r <= reg_wdata;
        end else if (day_carry) begin
            monthday_count_r <= monthday_value_nxt;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            calendar_month_count_r <= rtcal_pkg::REG_RESET;
        end else if (wr_month) begin
            calendar_month_count_r <= reg_wdata;
        end else if (day_carry && monthday_wrap) begin
            calendar_month_count_r <= month_nxt;
        end
    end

    // Alarm event is judged only after an update, so it fires once per match second
    always_ff @(posedge mclk) begin
        if (rst) begin
            alarm_event_r <= 1'b0;
            alarm_irq_r <= 1'b0;
        end else begin
            alarm_event_r <= time_updated && all_match;
            alarm_irq_r <= time_updated && all_match && alarm_int_enable;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            day_advance_r <= 1'b0;
        end else begin
            day_advance_r <= day_carry;
        end
    end

    // Read data is registered: valid the cycle after reg_rd, held until the next read
    always_ff @(posedge mclk) begin
        if (rst) begin
            reg_rdata_r <= rtcal_pkg::REG_RESET;
        end else if (reg_rd) begin
            unique case (reg_addr)
                rtcal_pkg::OFS_SEC_ALARM: reg_rdata_r <= sec_alarm_r;
                rtcal_pkg::OFS_MIN_ALARM: reg_rdata_r <= minutes_alarm_match_r;
                rtcal_pkg::OFS_HOUR: reg_rdata_r <= hour_count_r;
                rtcal_pkg::OFS_HOUR_ALARM: reg_rdata_r <= hour_alarm_match_r;
                rtcal_pkg::OFS_WEEKDAY: reg_rdata_r <= weekday_count_r;
                rtcal_pkg::OFS_MONTHDAY: reg_rdata_r <= monthday_count_r;
                rtcal_pkg::OFS_MONTH: reg_rdata_r <= calendar_month_count_r;
                default: reg_rdata_r <= rtcal_pkg::READ_UNMAPPED;
            endcase
        end
    end

    assign reg_rdata = reg_rdata_r;
    assign alarm_event = alarm_event_r;
    assign alarm_irq = alarm_irq_r;
    assign day_advance = day_advance_r;

endmodule : rtcal_regs

// ### rtcal_pkg.sv
// Constants for the calendar, hour and alarm-match register block.
// Assumes a byte-wide register port addressed by the offsets listed here.
package rtcal_pkg;

    localparam int ADDR_W = 6;
    localparam int DATA_W = 8;

    // Register offsets
    localparam logic [5:0] OFS_SEC_ALARM = 6'h01;
    localparam logic [5:0] OFS_MIN_ALARM = 6'h03;
    localparam logic [5:0] OFS_HOUR = 6'h04;
    localparam logic [5:0] OFS_HOUR_ALARM = 6'h05;
    localparam logic [5:0] OFS_WEEKDAY = 6'h06;
    localparam logic [5:0] OFS_MONTHDAY = 6'h07;
    localparam logic [5:0] OFS_MONTH = 6'h08;

    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // Hour register layout
    localparam int HALF_DAY_BIT = 7;
    localparam int HOUR_MSB = 6;

    // Alarm don't-care marker in the two top bits
    localparam logic [1:0] ALARM_ANY = 2'b11;

    // Count ranges, always in binary
    localparam logic [7:0] HOUR12_FIRST = 8'h01;
    localparam logic [7:0] HOUR12_LAST = 8'h0c;
    localparam logic [7:0] HOUR12_TURN = 8'h0b;
    localparam logic [7:0] HOUR24_FIRST = 8'h00;
    localparam logic [7:0] HOUR24_LAST = 8'h17;
    localparam logic [7:0] WEEKDAY_FIRST = 8'h01;
    localparam logic [7:0] WEEKDAY_LAST = 8'h07;
    localparam logic [7:0] MONTHDAY_FIRST = 8'h01;
    localparam logic [7:0] MONTH_FIRST = 8'h01;
    localparam logic [7:0] MONTH_LAST = 8'h0c;
    localparam logic [7:0] FEBRUARY = 8'h02;
    localparam logic [7:0] APRIL = 8'h04;
    localparam logic [7:0] JUNE = 8'h06;
    localparam logic [7:0] SEPTEMBER = 8'h09;
    localparam logic [7:0] NOVEMBER = 8'h0b;
    localparam logic [7:0] DAYS_LONG = 8'h1f;
    localparam logic [7:0] DAYS_SHORT = 8'h1e;
    localparam logic [7:0] DAYS_FEB = 8'h1c;
    localparam logic [7:0] DAYS_FEB_LEAP = 8'h1d;

    localparam logic [7:0] DECIMAL_BASE = 8'h0a;

endpackage : rtcal_pkg

// ### rtcal_step.sv
// One counter step of a calendar field, in binary or BCD presentation.
// Assumes the current value is a legal code of the selected presentation.
`timescale 1ns/1ps
module rtcal_step (
    input wire logic [7:0] cur,
    input wire logic bcd,
    input wire logic [7:0] first,
    input wire logic [7:0] last,
    output logic [7:0] nxt,
    output logic wrap,
    output logic [7:0] bin
);
    logic [7:0] nb;

    always_comb begin
        nb = 8'h00;
        bin = bcd ? 8'(({4'h0, cur[7:4]} * rtcal_pkg::DECIMAL_BASE) + {4'h0, cur[3:0]})
                  : cur;
        // Out-of-range values also wrap, so a bad write recovers at the next step
        wrap = (bin >= last);
        nb = wrap ? first : 8'(bin + 8'h01);
        nxt = bcd ? {4'(nb / rtcal_pkg::DECIMAL_BASE), 4'(nb % rtcal_pkg::DECIMAL_BASE)} : nb;
    end

endmodule : rtcal_step

// ### rtcal_regs_sva.sv
// Port checks for the hour, calendar and alarm-match register block.
// Assumes one clock domain, mclk, with a synchronous active-high rst.
`timescale 1ns/1ps
module rtcal_regs_sva (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [5:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic alarm_int_enable,
    input wire logic [7:0] seconds_now,
    input wire logic [7:0] minutes_now,
    input wire logic hour_tick,
    input wire logic time_updated,
    input wire logic alarm_event,
    input wire logic alarm_irq,
    input wire logic day_advance
);
    logic [7:0] sec_r, min_r, hra_r;
    logic mapped;
    localparam logic [1:0] ANY = rtcal_pkg::ALARM_ANY;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // Alarm registers change only by software, so a shadow of the writes suffices
    always_ff @(posedge mclk) begin
        if (rst) begin
            sec_r <= 8'h00;
            min_r <= 8'h00;
            hra_r <= 8'h00;
        end else if (reg_wr) begin
            if (reg_addr == rtcal_pkg::OFS_SEC_ALARM) sec_r <= reg_wdata;
            if (reg_addr == rtcal_pkg::OFS_MIN_ALARM) min_r <= reg_wdata;
            if (reg_addr == rtcal_pkg::OFS_HOUR_ALARM) hra_r <= reg_wdata;
        end
    end
    always_comb begin
        mapped = (reg_addr == rtcal_pkg::OFS_SEC_ALARM) ||
                 (reg_addr >= rtcal_pkg::OFS_MIN_ALARM && reg_addr <= rtcal_pkg::OFS_MONTH);
    end
    chk_irq_gated: assert property (alarm_irq == (alarm_event && $past(alarm_int_enable)))
        else $error("alarm irq does not follow event and enable");
    chk_event_cause: assert property (alarm_event |-> $past(time_updated))
        else $error("alarm event without time update");
    chk_sec_miss: assert property (time_updated && sec_r[7:6] != ANY
        && sec_r != seconds_now |=> !alarm_event) else $error("alarm on seconds mismatch");
    chk_min_miss: assert property (time_updated && min_r[7:6] != ANY
        && min_r != minutes_now |=> !alarm_event) else $error("alarm on minutes mismatch");
    chk_all_any: assert property (time_updated && sec_r[7:6] == ANY
        && min_r[7:6] == ANY && hra_r[7:6] == ANY |=> alarm_event)
        else $error("don't-care alarm missed");
    chk_day_cause: assert property (day_advance |-> $past(hour_tick))
        else $error("day advance without hour tick");
    chk_write_wins: assert property (hour_tick && reg_wr
        && reg_addr == rtcal_pkg::OFS_HOUR |=> !day_advance)
        else $error("day advance from a dropped hour tick");
    chk_min_read: assert property (reg_rd && reg_addr == rtcal_pkg::OFS_MIN_ALARM
        |=> reg_rdata == $past(min_r)) else $error("minutes alarm readback wrong");
    chk_unmapped_read: assert property (reg_rd && !mapped |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_rdata_hold: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
        else $error("read data moved without read");
endmodule : rtcal_regs_sva
bind rtcal_regs rtcal_regs_sva rtcal_regs_sva_inst (.mclk(mclk), .rst(rst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .alarm_int_enable(alarm_int_enable), .seconds_now(seconds_now),
    .minutes_now(minutes_now), .hour_tick(hour_tick), .time_updated(time_updated),
    .alarm_event(alarm_event), .alarm_irq(alarm_irq), .day_advance(day_advance));

// ### tb_rtcal_regs.sv
// Self-checking bench for the hour, calendar and alarm-match register block.
// Assumes the block stands alone; the bench drives every port at the falling edge.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); end end
module tb_rtcal_regs;
    logic mclk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [5:0] reg_addr = 6'h00;
    logic [7:0] reg_wdata = 8'h00, sec_now = 8'h00, min_now = 8'h00, reg_rdata;
    logic fmt_bin = 1'b1, h24 = 1'b1, alm_en = 1'b0, leap_year = 1'b0;
    logic hour_tick = 1'b0, time_updated = 1'b0, alarm_event, alarm_irq, day_advance;
    int num_errors = 0, comparisons = 0, cycles = 0;
    rtcal_regs rtcal_regs_inst (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .binary_format_select(fmt_bin), .hour_24_select(h24), .alarm_int_enable(alm_en),
        .leap_year(leap_year), .seconds_now(sec_now), .minutes_now(min_now),
        .hour_tick(hour_tick), .time_updated(time_updated), .alarm_event(alarm_event),
        .alarm_irq(alarm_irq), .day_advance(day_advance));
    initial begin
        forever #2.5 mclk = ~mclk;
    end
    // The whole run needs a few hundred cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : give_verdict
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge mclk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge mclk);
        reg_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        @(negedge mclk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge mclk);
        reg_rd = 1'b0;
        `CHK("reg_rdata", e, reg_rdata)
    endtask : rd
    task automatic tick(input logic [7:0] h, input logic [7:0] e, input logic da);
        wr(rtcal_pkg::OFS_HOUR, h);
        @(negedge mclk);
        hour_tick = 1'b1;
        @(negedge mclk);
        hour_tick = 1'b0;
        `CHK("day_advance", da, day_advance)
        rd(rtcal_pkg::OFS_HOUR, e);
    endtask : tick
    task automatic alarm(input logic [7:0] s, m, input logic en, ev, irq);
        sec_now = s;
        min_now = m;
        alm_en = en;
        @(negedge mclk);
        time_updated = 1'b1;
        @(negedge mclk);
        time_updated = 1'b0;
        `CHK("alarm_event", ev, alarm_event)
        `CHK("alarm_irq", irq, alarm_irq)
    endtask : alarm
    task automatic t_regs();
        logic [5:0] a;
        for (int i = 3; i <= 8; i++) begin
            a = 6'(i);
            rd(a, 8'h00);
            wr(a, 8'h5a ^ {2'h0, a});
            rd(a, 8'h5a ^ {2'h0, a});
        end
        wr(6'h02, 8'hff);
        rd(6'h02, 8'h00);
        rd(6'h3f, 8'h00);
    endtask : t_regs
    task automatic t_alarm();
        wr(6'h01, 8'h15);
        wr(6'h03, 8'h2a);
        wr(6'h04, 8'h0e);
        wr(6'h05, 8'h0e);
        alarm(8'h15, 8'h2a, 1'b1, 1'b1, 1'b1);
        alarm(8'h15, 8'h2a, 1'b0, 1'b1, 1'b0);
        alarm(8'h15, 8'h2b, 1'b1, 1'b0, 1'b0);
        alarm(8'h16, 8'h2a, 1'b1, 1'b0, 1'b0);
        wr(6'h05, 8'h0f);
        alarm(8'h15, 8'h2a, 1'b1, 1'b0, 1'b0);
        wr(6'h05, 8'hc0);
        wr(6'h03, 8'hff);
        wr(6'h01, 8'hc3);
        alarm(8'h40, 8'h2b, 1'b1, 1'b1, 1'b1);
    endtask : t_alarm
    task automatic t_day();
        fmt_bin = 1'b0;
        wr(6'h06, 8'h07);
        wr(6'h07, 8'h31);
        wr(6'h08, 8'h12);
        tick(8'h09, 8'h10, 1'b0);
        tick(8'h23, 8'h00, 1'b1);
        rd(6'h06, 8'h01);
        rd(6'h07, 8'h01);
        rd(6'h08, 8'h01);
        fmt_bin = 1'b1;
        wr(6'h06, 8'h03);
        wr(6'h07, 8'h1e);
        wr(6'h08, 8'h04);
        tick(8'h09, 8'h0a, 1'b0);
        tick(8'h17, 8'h00, 1'b1);
        rd(6'h06, 8'h04);
        rd(6'h07, 8'h01);
        rd(6'h08, 8'h05);
    endtask : t_day
    // Hour write and hour tick on one edge: the write lands and no day carry follows
    task automatic t_write_wins();
        wr(rtcal_pkg::OFS_HOUR, 8'h17);
        wr(rtcal_pkg::OFS_WEEKDAY, 8'h05);
        @(negedge mclk);
        reg_addr = rtcal_pkg::OFS_HOUR;
        reg_wdata = 8'h09;
        reg_wr = 1'b1;
        hour_tick = 1'b1;
        @(negedge mclk);
        reg_wr = 1'b0;
        hour_tick = 1'b0;
        `CHK("day_advance", 1'b0, day_advance)
        rd(rtcal_pkg::OFS_HOUR, 8'h09);
        rd(rtcal_pkg::OFS_WEEKDAY, 8'h05);
    endtask : t_write_wins
    task automatic t_leap();
        leap_year = 1'b1;
        wr(6'h08, 8'h02);
        wr(6'h07, 8'h1c);
        tick(8'h17, 8'h00, 1'b1);
        rd(6'h07, 8'h1d);
        tick(8'h17, 8'h00, 1'b1);
        rd(6'h07, 8'h01);
        rd(6'h08, 8'h03);
        leap_year = 1'b0;
        wr(6'h08, 8'h02);
        wr(6'h07, 8'h1c);
        tick(8'h17, 8'h00, 1'b1);
        rd(6'h07, 8'h01);
        rd(6'h08, 8'h03);
    endtask : t_leap
    task automatic t_half_day();
        h24 = 1'b0;
        fmt_bin = 1'b0;
        tick(8'h11, 8'h92, 1'b0);
        tick(8'h91, 8'h12, 1'b1);
        tick(8'h12, 8'h01, 1'b0);
        fmt_bin = 1'b1;
        tick(8'h8b, 8'h0c, 1'b1);
    endtask : t_half_day
    initial begin
        repeat (16) @(posedge mclk);
        @(negedge mclk);
        rst = 1'b0;
        t_regs();
        t_alarm();
        t_day();
        t_write_wins();
        t_leap();
        t_half_day();
        give_verdict();
    end
endmodule : tb_rtcal_regs
